// ### rtl/bxcv_top.sv
// Top of the 18-bit bidirectional transceiver, modelled on one system clock.
// Assumes control, data and power-good pins are asynchronous to CLOCK; each passes two flip-flops.
// Pin clocks are sampled and their rising edges detected as enables.
//
// Functional notes
// - Eighteen bits carried each way, never inverted.
// - Each direction owns clock enable, latch enable, clock, output enable.
// - A-to-B: enables low, rising clock stores card data onto backplane.
// - Falling latch enable closes path, holding data present then.
// - Latch enable high passes card data straight through.
// - Both enables low without clock edge keeps stored value.
// - Backplane outputs driven only while a-to-b output enable low.
// - Clock enable high, latch enable low: clock edges ignored.
// - Clock resting high holds old value, also if it rose while clock enable was high.
// - Backplane-to-card direction behaves identically with its own controls.
// - Outputs isolated while supply low; enables held high until ready.
`timescale 1ns/1ps
module bxcv_top (
  // Clock and reset
  input wire logic CLOCK,
  input wire logic SYS_RST,
  // Power status
  input wire logic POWER_GOOD,
  // Card-side port
  input wire logic [17:0] CARD_IN,
  output logic [17:0] CARD_OUT,
  output logic CARD_OE,
  // Backplane-side port
  input wire logic [17:0] BACK_IN,
  output logic [17:0] BACK_OUT,
  output logic BACK_OE,
  // A-to-B controls
  input wire logic A2B_CLOCK_ENABLE_N,
  input wire logic A2B_LATCH_ENABLE,
  input wire logic A2B_CLOCK,
  input wire logic A2B_OUTPUT_ENABLE_N,
  // B-to-A controls
  input wire logic B2A_CLOCK_ENABLE_N,
  input wire logic B2A_LATCH_ENABLE,
  input wire logic B2A_CLOCK,
  input wire logic B2A_OUTPUT_ENABLE_N,
  // Stream tap of stored card data
  output logic STREAM_VALID,
  input wire logic STREAM_READY,
  output logic [17:0] STREAM_DATA,
  output logic STREAM_OVERFLOW
);
  localparam int W = bxcv_pkg::DATA_W;
  // Per direction: 0 is a-to-b, 1 is b-to-a
  bxcv_pkg::bxcv_ctrl_t ctrl_pin [2];
  bxcv_pkg::bxcv_ctrl_t ctrl_s1 [2];
  bxcv_pkg::bxcv_ctrl_t ctrl [2];
  logic [W-1:0] din_s1 [2];
  logic [W-1:0] din [2];
  logic [W-1:0] store [2];
  logic clk_prev [2];
  logic clk_edge [2];
  bxcv_pkg::bxcv_mode_t mode [2];
  bxcv_pkg::bxcv_drive_t drive [2];
  logic pg_s1;
  logic pg;
  logic fifo_ready;
  logic a2b_captured;

  assign ctrl_pin[0] = '{A2B_CLOCK_ENABLE_N, A2B_LATCH_ENABLE, A2B_CLOCK, A2B_OUTPUT_ENABLE_N};
  assign ctrl_pin[1] = '{B2A_CLOCK_ENABLE_N, B2A_LATCH_ENABLE, B2A_CLOCK, B2A_OUTPUT_ENABLE_N};

  // Power-good synchroniser
  always_ff @(posedge CLOCK) begin
    if (SYS_RST) begin
      pg_s1 <= bxcv_pkg::PGOOD_RST;
      pg <= bxcv_pkg::PGOOD_RST;
    end else begin
      pg_s1 <= POWER_GOOD;
      pg <= pg_s1;
    end
  end

  genvar d;
  generate
    for (d = 0; d < 2; d++) begin : g_dir
      always_ff @(posedge CLOCK) begin
        if (SYS_RST) begin
          // Clock reset high: a pin resting high gives no false edge
          ctrl_s1[d] <= bxcv_pkg::CTRL_RST;
          ctrl[d] <= bxcv_pkg::CTRL_RST;
          din_s1[d] <= bxcv_pkg::STORE_RST;
          din[d] <= bxcv_pkg::STORE_RST;
          clk_prev[d] <= bxcv_pkg::CTRL_RST.clock;
        end else begin
          ctrl_s1[d] <= ctrl_pin[d];
          ctrl[d] <= ctrl_s1[d];
          din_s1[d] <= (d == 0) ? CARD_IN : BACK_IN;
          din[d] <= din_s1[d];
          clk_prev[d] <= ctrl[d].clock;
        end
      end

      assign clk_edge[d] = ctrl[d].clock && !clk_prev[d];

      // Mode decode
      always_comb begin
        if (ctrl[d].latch_enable) begin
          mode[d] = bxcv_pkg::BXCV_TRANSPARENT;
        end else if (!ctrl[d].clock_enable_n) begin
          mode[d] = bxcv_pkg::BXCV_CLOCKED;
        end else begin
          mode[d] = bxcv_pkg::BXCV_INHIBIT;
        end
      end

      always_ff @(posedge CLOCK) begin
        if (SYS_RST) begin
          store[d] <= bxcv_pkg::STORE_RST;
        end else begin
          unique case (mode[d])
            // transparent follow, last value held at fall
            bxcv_pkg::BXCV_TRANSPARENT: store[d] <= din[d];
            // capture on rising clock, hold otherwise
            bxcv_pkg::BXCV_CLOCKED: if (clk_edge[d]) begin
              store[d] <= din[d];
            end
            bxcv_pkg::BXCV_INHIBIT: store[d] <= store[d];
          endcase
        end
      end

      always_ff @(posedge CLOCK) begin
        if (SYS_RST) begin
          drive[d] <= '{bxcv_pkg::STORE_RST, 1'b0};
        end else begin
          drive[d].data <= (mode[d] == bxcv_pkg::BXCV_TRANSPARENT) ? din[d] : store[d];
          drive[d].oe <= pg && !ctrl[d].output_enable_n;
        end
      end
    end
  endgenerate

  assign BACK_OUT = drive[0].data;
  assign BACK_OE = drive[0].oe;
  assign CARD_OUT = drive[1].data;
  assign CARD_OE = drive[1].oe;

  // Stream tap: each clocked a-to-b capture is queued while the FIFO has room
  assign a2b_captured = (mode[0] == bxcv_pkg::BXCV_CLOCKED) && clk_edge[0];

  // Sticky overflow when a capture finds the FIFO full
  always_ff @(posedge CLOCK) begin
    if (SYS_RST) begin
      STREAM_OVERFLOW <= 1'b0;
    end else if (a2b_captured && !fifo_ready) begin
      STREAM_OVERFLOW <= 1'b1;
    end
  end

  bxcv_fifo #(.WIDTH(W), .DEPTH(bxcv_pkg::FIFO_DEPTH)) u_fifo (
    .clk(CLOCK),
    .rst(SYS_RST),
    .in_valid(a2b_captured),
    .in_ready(fifo_ready),
    .in_data(din[0]),
    .out_valid(STREAM_VALID),
    .out_ready(STREAM_READY),
    .out_data(STREAM_DATA)
  );

  // Checks
  // enable, isolation and data path
  a_back_oe_follow: assert property (@(posedge CLOCK) disable iff (SYS_RST)
    ctrl[0].output_enable_n |=> !BACK_OE)
    else $error("backplane driven while disabled");
  a_card_oe_follow: assert property (@(posedge CLOCK) disable iff (SYS_RST)
    ctrl[1].output_enable_n |=> !CARD_OE)
    else $error("card driven while disabled");
  a_pg_isolate: assert property (@(posedge CLOCK) disable iff (SYS_RST)
    !pg |=> !BACK_OE && !CARD_OE)
    else $error("outputs driven without power good");
  a_transp_pass: assert property (@(posedge CLOCK) disable iff (SYS_RST)
    ctrl[0].latch_enable |=> BACK_OUT == $past(din[0]))
    else $error("transparent path wrong");
  a_clk_capture: assert property (@(posedge CLOCK) disable iff (SYS_RST)
    mode[0] == bxcv_pkg::BXCV_CLOCKED && clk_edge[0] |=> store[0] == $past(din[0]))
    else $error("clock edge not captured");
  a_inhibit_hold: assert property (@(posedge CLOCK) disable iff (SYS_RST)
    mode[0] == bxcv_pkg::BXCV_INHIBIT |=> $stable(store[0]))
    else $error("inhibit changed store");
  a_latched_hold: assert property (@(posedge CLOCK) disable iff (SYS_RST)
    mode[0] == bxcv_pkg::BXCV_CLOCKED && !clk_edge[0] |=> $stable(store[0]))
    else $error("latched value changed");
  a_latch_fall: assert property (@(posedge CLOCK) disable iff (SYS_RST)
    $fell(ctrl[1].latch_enable) && !clk_edge[1] |-> store[1] == $past(din[1]))
    else $error("latch fall lost data");
  a_a2b_fall_hold: assert property (@(posedge CLOCK) disable iff (SYS_RST)
    $fell(ctrl[0].latch_enable) |-> store[0] == $past(din[0]))
    else $error("a-to-b latch fall lost data");
  a_b2a_capture: assert property (@(posedge CLOCK) disable iff (SYS_RST)
    mode[1] == bxcv_pkg::BXCV_CLOCKED && clk_edge[1] |=> store[1] == $past(din[1]))
    else $error("b-to-a clock edge not captured");
  a_store_drive: assert property (@(posedge CLOCK) disable iff (SYS_RST)
    mode[0] != bxcv_pkg::BXCV_TRANSPARENT |=> BACK_OUT == $past(store[0]))
    else $error("backplane data differs from store");
  a_b2a_inhibit: assert property (@(posedge CLOCK) disable iff (SYS_RST)
    mode[1] == bxcv_pkg::BXCV_INHIBIT |=> $stable(store[1]))
    else $error("b-to-a inhibit changed store");
  c_b2a_clocked: cover property (@(posedge CLOCK)
    mode[1] == bxcv_pkg::BXCV_CLOCKED && clk_edge[1]);
  c_transparent: cover property (@(posedge CLOCK) BACK_OE && mode[0] == bxcv_pkg::BXCV_TRANSPARENT);
  c_clocked: cover property (@(posedge CLOCK) a2b_captured ##1 BACK_OE);
  c_fifo_full: cover property (@(posedge CLOCK) !fifo_ready);
endmodule // bxcv_top

// ### rtl/bxcv_pkg.sv
// Package for the bidirectional latched and registered transceiver.
// Assumes one system clock; both data directions share these types.
package bxcv_pkg;

  // Data path width in each direction
  localparam int DATA_W = 18;
  // Depth of the stream FIFO in the card-to-backplane path
  localparam int FIFO_DEPTH = 16;
  // Reset value of the data stores, data synchronisers and output data
  localparam logic [17:0] STORE_RST = 18'h00000;
  // Power-good reset value (low: outputs isolated)
  localparam logic PGOOD_RST = 1'b0;

  // Controls of one direction
  typedef struct packed {
    logic clock_enable_n;
    logic latch_enable;
    logic clock;
    logic output_enable_n;
  } bxcv_ctrl_t;

  // Control reset: enables inactive, clock taken as resting high
  localparam bxcv_ctrl_t CTRL_RST = '{1'b1, 1'b0, 1'b1, 1'b1};

  // Driven side of one port
  typedef struct packed {
    logic [17:0] data;
    logic oe;
  } bxcv_drive_t;

  // Storage mode of one direction
  typedef enum logic [1:0] {
    BXCV_TRANSPARENT,
    BXCV_CLOCKED,
    BXCV_INHIBIT
  } bxcv_mode_t;

endpackage

// ### rtl/bxcv_fifo.sv
// Synchronous FIFO with valid/ready on both sides.
// Assumes one clock and a synchronous active-high reset.
`timescale 1ns/1ps
module bxcv_fifo #(
  parameter int WIDTH = 18,
  parameter int DEPTH = 16
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Fill side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  // Drain side
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0] wr_ptr;
  logic [AW:0] rd_ptr;
  logic push;
  logic pop;

  // Honest full and empty flags
  assign in_ready = (wr_ptr - rd_ptr) != (AW+1)'(DEPTH);
  assign out_valid = wr_ptr != rd_ptr;
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;
  assign out_data = mem[rd_ptr[AW-1:0]];

  // Storage write
  always_ff @(posedge clk) begin
    if (push) begin
      mem[wr_ptr[AW-1:0]] <= in_data;
    end
  end

  // Pointers
  always_ff @(posedge clk) begin
    if (rst) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
    end else begin
      if (push) begin
        wr_ptr <= wr_ptr + 1'b1;
      end
      if (pop) begin
        rd_ptr <= rd_ptr + 1'b1;
      end
    end
  end
endmodule // bxcv_fifo

// ### sim/bxcv_bus_model.sv
// Backplane bus model: resolves the shared backplane wire.
// Assumes the block raises its drive enable only while it drives.
`timescale 1ns/1ps
module bxcv_bus_model (
  // Clock
  input wire logic clk,
  // Block side
  input wire logic dev_oe,
  input wire logic [17:0] dev_data,
  // Remote card on the bus
  input wire logic far_en,
  input wire logic [17:0] far_data,
  // Resolved wire
  output logic [17:0] wire_level
);
  logic [17:0] churn = 18'h15555;
  // Undriven bus shows a pattern that flips every cycle
  always_ff @(posedge clk) begin
    churn <= ~churn;
  end
  assign wire_level = dev_oe ? dev_data : (far_en ? far_data : churn);
endmodule // bxcv_bus_model

// ### sim/bxcv_top_tb.sv
// Self-checking bench for the transceiver top.
// Assumes the backplane model above; card pins are resolved here.
`timescale 1ns/1ps
module bxcv_top_tb;
  logic clk = 1'b0, rst = 1'b1, pgood = 1'b0, ready = 1'b0, far_en = 1'b0;
  logic a_cen = 1'b1, a_le = 1'b0, a_ck = 1'b0, a_oen = 1'b1;
  logic b_cen = 1'b1, b_le = 1'b0, b_ck = 1'b0, b_oen = 1'b1;
  logic [17:0] card_drv = 18'h00000, far_data = 18'h00000, card_w, back_w;
  logic [17:0] card_out, back_out, s_data;
  logic card_oe, back_oe, s_valid, s_ovf;
  int error_cnt = 0, n_checks = 0;
  // Card pin level from both drivers
  assign card_w = card_oe ? card_out : card_drv;
  // Clock, 50 ns period
  initial begin
    forever #25 clk = ~clk;
  end
  bxcv_top dut (.CLOCK(clk), .SYS_RST(rst), .POWER_GOOD(pgood),
    .CARD_IN(card_w), .CARD_OUT(card_out), .CARD_OE(card_oe),
    .BACK_IN(back_w), .BACK_OUT(back_out), .BACK_OE(back_oe),
    .A2B_CLOCK_ENABLE_N(a_cen), .A2B_LATCH_ENABLE(a_le), .A2B_CLOCK(a_ck),
    .A2B_OUTPUT_ENABLE_N(a_oen), .B2A_CLOCK_ENABLE_N(b_cen), .B2A_LATCH_ENABLE(b_le),
    .B2A_CLOCK(b_ck), .B2A_OUTPUT_ENABLE_N(b_oen), .STREAM_VALID(s_valid),
    .STREAM_READY(ready), .STREAM_DATA(s_data), .STREAM_OVERFLOW(s_ovf));
  bxcv_bus_model bus (.clk(clk), .dev_oe(back_oe), .dev_data(back_out),
    .far_en(far_en), .far_data(far_data), .wire_level(back_w));
  task automatic chk(input string what, input logic [17:0] exp, input logic [17:0] got);
    n_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(negedge clk);
  endtask
  task automatic pulse_a;
    a_ck = 1'b1;
    cyc(3);
    a_ck = 1'b0;
    cyc(6);
  endtask
  task automatic tally_and_finish;
    $display("checks %0d errors %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task automatic t_a2b;
    pgood = 1'b1;
    a_oen = 1'b0;
    a_le = 1'b1;
    card_drv = 18'h2a5c3;
    cyc(6);
    chk("back transparent", 18'h2a5c3, back_out);
    chk("back oe", 18'h00001, 18'(back_oe));
    card_drv = 18'h3c0f1;
    cyc(6);
    a_le = 1'b0;
    cyc(1);
    card_drv = 18'h0ff00;
    cyc(6);
    chk("back latched", 18'h3c0f1, back_out);
    a_ck = 1'b1;
    cyc(6);
    chk("back inhibit", 18'h3c0f1, back_out);
    a_cen = 1'b0;
    cyc(6);
    chk("back clock high", 18'h3c0f1, back_out);
    a_ck = 1'b0;
    cyc(4);
    chk("back clock low", 18'h3c0f1, back_out);
    pulse_a();
    chk("back clocked", 18'h0ff00, back_out);
  endtask
  task automatic t_fifo;
    int cnt;
    cnt = 0;
    for (int i = 1; i <= 16; i++) begin
      card_drv = 18'(i) ^ 18'h2aaaa;
      cyc(3);
      pulse_a();
    end
    chk("overflow", 18'h00001, 18'(s_ovf));
    ready = 1'b1;
    for (int k = 0; k < 40 && s_valid === 1'b1; k++) begin
      if (cnt == 0) chk("first word", 18'h0ff00, s_data);
      else chk("queued word", 18'(cnt) ^ 18'h2aaaa, s_data);
      cnt++;
      cyc(1);
    end
    ready = 1'b0;
    chk("drained words", 18'h00010, 18'(cnt));
    chk("empty", 18'h00000, 18'(s_valid));
    if (s_valid !== 1'b0) tally_and_finish();
  endtask
  task automatic t_b2a;
    // one output enable low at a time
    a_oen = 1'b1;
    far_en = 1'b1;
    far_data = 18'h2b4d1;
    b_le = 1'b1;
    b_oen = 1'b0;
    cyc(6);
    chk("card transparent", 18'h2b4d1, card_out);
    chk("back isolated", 18'h00000, 18'(back_oe));
    b_le = 1'b0;
    b_cen = 1'b0;
    cyc(1);
    far_data = 18'h1e2d3;
    cyc(3);
    b_ck = 1'b1;
    cyc(3);
    b_ck = 1'b0;
    cyc(6);
    chk("card clocked", 18'h1e2d3, card_out);
    pgood = 1'b0;
    cyc(6);
    chk("card oe no power", 18'h00000, 18'(card_oe));
    pgood = 1'b1;
    cyc(6);
    chk("card oe power", 18'h00001, 18'(card_oe));
  endtask
  task automatic t_rest_reset;
    // clock resting high across a reset is no edge
    b_oen = 1'b1;
    a_cen = 1'b0;
    a_le = 1'b0;
    a_ck = 1'b1;
    rst = 1'b1;
    cyc(3);
    a_oen = 1'b0;
    rst = 1'b0;
    cyc(8);
    chk("rest back data", 18'h00000, back_out);
    chk("rest back oe", 18'h00001, 18'(back_oe));
    chk("rest card oe", 18'h00000, 18'(card_oe));
    chk("rest valid", 18'h00000, 18'(s_valid));
    chk("rest overflow", 18'h00000, 18'(s_ovf));
  endtask
  // Watchdog against a hang
  initial begin
    #2000000;
    error_cnt++;
    tally_and_finish();
  end
  // Main sequence, enables held high until ready
  initial begin
    cyc(3);
    chk("reset back oe", 18'h00000, 18'(back_oe));
    chk("reset valid", 18'h00000, 18'(s_valid));
    rst = 1'b0;
    cyc(3);
    t_a2b();
    t_fifo();
    t_b2a();
    t_rest_reset();
    tally_and_finish();
  end
endmodule // bxcv_top_tb
